// ==== hw/usfl_pkg.sv ====
// Package for the serial transceiver status and flag block.
// Shared by the status logic and its pin synchroniser; no other dependency.
package usfl_pkg;

  // I/O addresses on the internal bus
  localparam logic [7:0] USFL_DATA_ADDR = 8'h38;
  localparam logic [7:0] USFL_CTRL_ADDR = 8'h39;

  // Status word bit positions
  localparam int USFL_ST_TXBUF  = 0;
  localparam int USFL_ST_RXAV   = 1;
  localparam int USFL_ST_TXIDLE = 2;
  localparam int USFL_ST_PAR    = 3;
  localparam int USFL_ST_OVR    = 4;
  localparam int USFL_ST_FRM    = 5;
  localparam int USFL_ST_SYBK   = 6;
  localparam int USFL_ST_DSR    = 7;

  // Command bit positions
  localparam int USFL_CMD_TXEN   = 0;
  localparam int USFL_CMD_RXEN   = 2;
  localparam int USFL_CMD_ERRCLR = 4;
  localparam int USFL_CMD_SRESET = 6;
  localparam int USFL_CMD_HUNT   = 7;

  // Mode byte fields
  localparam int         USFL_MODE_EXTSYNC = 6;
  localparam int         USFL_MODE_SINGLE  = 7;
  localparam logic [1:0] USFL_MODE_SYNCSEL = 2'h0;

  // All-zero characters tolerated before a break is flagged
  localparam logic [1:0] USFL_BREAK_CHARS = 2'h2;

  // Reset values
  localparam logic [7:0] USFL_RDATA_RST = 8'h00;
  localparam logic [1:0] USFL_ZCNT_RST  = 2'h0;

  // Pin synchroniser width
  localparam int USFL_NPINS = 5;

  typedef enum logic [1:0] {
    USFL_INIT_MODE,
    USFL_INIT_SYNC1,
    USFL_INIT_SYNC2,
    USFL_INIT_CMD
  } usfl_init_t;

  typedef struct packed {
    logic [7:0] addr;
    logic       rd;
    logic       wr;
    logic [7:0] wdata;
  } usfl_io_req_t;

  // Events from the transmitter and receiver cores, same clock
  typedef struct packed {
    logic tx_buf_empty;
    logic tx_idle;
    logic rx_done;
    logic rx_parity_bad;
    logic rx_stop_low;
    logic rx_zero_char;
    logic sync_match;
  } usfl_core_ev_t;

  // Raw pins from outside the clock domain
  typedef struct packed {
    logic cts_n;
    logic dsr_n;
    logic rxd;
    logic ext_sync_in;
    logic receive_clock;
  } usfl_pins_t;

  typedef struct packed {
    usfl_init_t init;
    logic       async_mode;
    logic       ext_sync;
    logic       single_sync;
    logic       txen;
    logic       rxen;
    logic       hunt;
    logic       rx_avail;
    logic       parity;
    logic       overrun;
    logic       frame;
    logic       sync_or_break_seen;
    logic [1:0] zero_cnt;
    logic       and_line;
    logic       rd_ctrl_prev;
    logic       rd_data_prev;
    logic [7:0] rdata;
  } usfl_state_t;

endpackage : usfl_pkg

// ==== hw/usfl_sync2.sv ====
// Two-stage synchroniser for a group of asynchronous pins.
// Assumes pins are quasi-static relative to sys_clk; no glitch filtering.
module usfl_sync2
  import usfl_pkg::*;
#(
  parameter int W = USFL_NPINS
) (
  input  logic         sys_clk,
  input  logic         arst_n,
  input  logic         clk_en,
  input  logic [W-1:0] pin_raw,
  output logic [W-1:0] pin_sync
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } usfl_sync_st_t;

  usfl_sync_st_t st_ff;
  usfl_sync_st_t nxt_st;

  always_comb begin
    nxt_st    = st_ff;
    nxt_st.s1 = pin_raw;
    nxt_st.s2 = st_ff.s1;
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_ff <= '0;
    end else if (clk_en) begin
      st_ff <= nxt_st;
    end
  end

  assign pin_sync = st_ff.s2;

endmodule : usfl_sync2

// ==== hw/usfl_status.sv ====
// Status word and flag logic of the serial transceiver.
// Assumes core events are one-cycle pulses on sys_clk and that the CPU
// holds addr stable through a read; wr is a one-cycle strobe.
module usfl_status
  import usfl_pkg::*;
(
  input  logic          sys_clk,
  input  logic          arst_n,
  input  logic          clk_en,
  input  usfl_io_req_t  io_req,
  output logic [7:0]    io_rdata,
  input  usfl_core_ev_t core_ev,
  input  usfl_pins_t    pins,
  output logic          tx_ready_line,
  output logic          rx_char_available,
  output logic          tx_idle,
  output logic          sync_break_line,
  output logic          hunt_active,
  output logic          sync_mode
);

  usfl_state_t st_ff;
  usfl_state_t nxt_st;
  usfl_pins_t  pin_s;

  logic       rd_ctrl;
  logic       rd_data;
  logic       cmd_wr;
  logic       mode_wr;
  logic       data_read;
  logic       read_end;
  logic       err_clr;
  logic       rx_off;
  logic       hunt_cmd;
  logic       in_hunt;
  logic       sync_set;
  logic       brk_set;
  logic [7:0] live_status;

  function automatic logic is_addr(usfl_io_req_t r, logic [7:0] a);
    is_addr = (r.addr == a);
  endfunction : is_addr

  // Flag update with an event in the clearing cycle kept alive
  function automatic logic flag_upd(logic cur, logic set, logic clr);
    flag_upd = set | (cur & ~clr);
  endfunction : flag_upd

  usfl_sync2 #(
    .W (USFL_NPINS)
  ) u_pin_sync (
    .sys_clk  (sys_clk),
    .arst_n   (arst_n),
    .clk_en   (clk_en),
    .pin_raw  (pins),
    .pin_sync (pin_s)
  );

  assign rd_ctrl   = io_req.rd & is_addr(io_req, USFL_CTRL_ADDR);
  assign rd_data   = io_req.rd & is_addr(io_req, USFL_DATA_ADDR);
  assign data_read = rd_data & ~st_ff.rd_data_prev;
  assign read_end  = st_ff.rd_ctrl_prev & ~rd_ctrl;
  assign cmd_wr    = io_req.wr & is_addr(io_req, USFL_CTRL_ADDR)
                     & (st_ff.init == USFL_INIT_CMD);
  assign mode_wr   = io_req.wr & is_addr(io_req, USFL_CTRL_ADDR)
                     & (st_ff.init == USFL_INIT_MODE);
  assign err_clr   = cmd_wr & io_req.wdata[USFL_CMD_ERRCLR];
  assign rx_off    = cmd_wr & ~io_req.wdata[USFL_CMD_RXEN];
  assign hunt_cmd  = cmd_wr & io_req.wdata[USFL_CMD_HUNT] & ~st_ff.async_mode;
  assign in_hunt   = st_ff.hunt & ~st_ff.async_mode;

  // External detection listens only to the clock-qualified line
  assign sync_set  = ~st_ff.async_mode &
                     (st_ff.ext_sync ? st_ff.and_line
                                     : core_ev.sync_match);
  assign brk_set   = st_ff.async_mode & core_ev.rx_zero_char
                     & (st_ff.zero_cnt == USFL_BREAK_CHARS);

  always_comb begin
    live_status                 = '0;
    live_status[USFL_ST_TXBUF]  = core_ev.tx_buf_empty;
    live_status[USFL_ST_RXAV]   = st_ff.rx_avail;
    live_status[USFL_ST_TXIDLE] = core_ev.tx_idle;
    live_status[USFL_ST_PAR]    = st_ff.parity;
    live_status[USFL_ST_OVR]    = st_ff.overrun;
    live_status[USFL_ST_FRM]    = st_ff.frame;
    live_status[USFL_ST_SYBK]   = st_ff.sync_or_break_seen;
    live_status[USFL_ST_DSR]    = ~pin_s.dsr_n;
  end

  always_comb begin
    nxt_st              = st_ff;
    nxt_st.rd_ctrl_prev = rd_ctrl;
    nxt_st.rd_data_prev = rd_data;
    nxt_st.and_line     = pin_s.ext_sync_in & pin_s.receive_clock;

    // Snapshot tracks live flags, frozen for the whole read
    nxt_st.rdata = rd_ctrl ? st_ff.rdata : live_status;

    // Initialisation sequence: mode, sync chars, then commands
    case (st_ff.init)
      USFL_INIT_MODE: begin
        if (mode_wr) begin
          nxt_st.async_mode  = (io_req.wdata[1:0] != USFL_MODE_SYNCSEL);
          nxt_st.ext_sync    = io_req.wdata[USFL_MODE_EXTSYNC];
          nxt_st.single_sync = io_req.wdata[USFL_MODE_SINGLE];
          nxt_st.init = (io_req.wdata[1:0] != USFL_MODE_SYNCSEL)
                        ? USFL_INIT_CMD : USFL_INIT_SYNC1;
        end
      end
      USFL_INIT_SYNC1: begin
        if (io_req.wr && is_addr(io_req, USFL_CTRL_ADDR)) begin
          nxt_st.init = st_ff.single_sync ? USFL_INIT_CMD : USFL_INIT_SYNC2;
        end
      end
      USFL_INIT_SYNC2: begin
        if (io_req.wr && is_addr(io_req, USFL_CTRL_ADDR)) begin
          nxt_st.init = USFL_INIT_CMD;
        end
      end
      USFL_INIT_CMD: begin
        if (cmd_wr) begin
          nxt_st.txen = io_req.wdata[USFL_CMD_TXEN];
          nxt_st.rxen = io_req.wdata[USFL_CMD_RXEN];
        end
      end
      default: begin
        nxt_st.init = USFL_INIT_MODE;
      end
    endcase

    // Hunt ends once sync is found
    if (hunt_cmd) begin
      nxt_st.hunt = 1'b1;
    end else if (sync_set) begin
      nxt_st.hunt = 1'b0;
    end

    // Receive disabled blocks overrun, and rx_avail in async only; parity and frame still set
    nxt_st.rx_avail = flag_upd(st_ff.rx_avail,
                        core_ev.rx_done & (st_ff.rxen | ~st_ff.async_mode),
                        data_read | rx_off | hunt_cmd);
    nxt_st.parity   = flag_upd(st_ff.parity,
                        core_ev.rx_parity_bad & ~in_hunt,
                        err_clr);
    nxt_st.overrun  = flag_upd(st_ff.overrun,
                        core_ev.rx_done & st_ff.rxen & st_ff.rx_avail,
                        err_clr | rx_off);
    nxt_st.frame    = flag_upd(st_ff.frame,
                        core_ev.rx_stop_low & st_ff.async_mode,
                        err_clr);

    // Zero-character run since the start bit, saturating
    if (!st_ff.async_mode || pin_s.rxd) begin
      nxt_st.zero_cnt = USFL_ZCNT_RST;
    end else if (core_ev.rx_zero_char &&
                 st_ff.zero_cnt != USFL_BREAK_CHARS) begin
      nxt_st.zero_cnt = st_ff.zero_cnt + 2'h1;
    end

    if (st_ff.async_mode) begin
      nxt_st.sync_or_break_seen = flag_upd(st_ff.sync_or_break_seen, brk_set, pin_s.rxd);
    end else begin
      nxt_st.sync_or_break_seen = flag_upd(st_ff.sync_or_break_seen, sync_set, read_end);
    end

    // Software reset returns to mode entry with everything quiet
    if (cmd_wr && io_req.wdata[USFL_CMD_SRESET]) begin
      nxt_st.init     = USFL_INIT_MODE;
      nxt_st.txen     = 1'b0;
      nxt_st.rxen     = 1'b0;
      nxt_st.hunt     = 1'b0;
      nxt_st.rx_avail = 1'b0;
      nxt_st.parity   = 1'b0;
      nxt_st.overrun  = 1'b0;
      nxt_st.frame    = 1'b0;
      nxt_st.sync_or_break_seen     = 1'b0;
      nxt_st.zero_cnt = USFL_ZCNT_RST;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_ff              <= '0;
      st_ff.init         <= USFL_INIT_MODE;
      st_ff.rdata        <= USFL_RDATA_RST;
      st_ff.zero_cnt     <= USFL_ZCNT_RST;
    end else if (clk_en) begin
      st_ff <= nxt_st;
    end
  end

  // Status snapshot driven onto the bus whatever the address, data reads included
  assign io_rdata          = st_ff.rdata;
  assign tx_ready_line     = core_ev.tx_buf_empty & ~pin_s.cts_n
                             & st_ff.txen;
  assign rx_char_available = st_ff.rx_avail;
  assign tx_idle           = core_ev.tx_idle;
  assign sync_break_line   = st_ff.sync_or_break_seen;
  assign hunt_active       = in_hunt;
  assign sync_mode         = ~st_ff.async_mode;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  property p_tx_ready;
    tx_ready_line == (core_ev.tx_buf_empty && !pin_s.cts_n && st_ff.txen);
  endproperty
  a_tx_ready: assert property (p_tx_ready)
    else $error("tx ready line mismatch");

  // Judged from the command stream, not from the line's own expression
  property p_tx_off;
    (clk_en && cmd_wr && !io_req.wdata[USFL_CMD_TXEN]) |=> !tx_ready_line;
  endproperty
  a_tx_off: assert property (p_tx_off)
    else $error("ready line high with transmit off");

  property p_txbuf_bit;
    (clk_en && !rd_ctrl) |=> io_rdata[USFL_ST_TXBUF] == $past(core_ev.tx_buf_empty);
  endproperty
  a_txbuf_bit: assert property (p_txbuf_bit)
    else $error("status bit 0 not buffer empty");

  property p_par_set;
    (clk_en && core_ev.rx_parity_bad && !in_hunt && !cmd_wr) |=> st_ff.parity;
  endproperty
  a_par_set: assert property (p_par_set)
    else $error("parity flag not set");

  property p_par_hunt;
    (clk_en && in_hunt && !st_ff.parity) |=> !st_ff.parity;
  endproperty
  a_par_hunt: assert property (p_par_hunt)
    else $error("parity flag changed in hunt");

  property p_ovr_set;
    (clk_en && core_ev.rx_done && st_ff.rxen && st_ff.rx_avail
     && !cmd_wr) |=> st_ff.overrun;
  endproperty
  a_ovr_set: assert property (p_ovr_set)
    else $error("overrun not set");

  property p_ovr_clr;
    (clk_en && rx_off && !core_ev.rx_done) |=> !st_ff.overrun && !st_ff.rx_avail;
  endproperty
  a_ovr_clr: assert property (p_ovr_clr)
    else $error("receive disable did not clear");

  property p_freeze;
    (clk_en && rd_ctrl) |=> $stable(io_rdata);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("status changed during read");

  property p_sync_clr;
    (clk_en && !st_ff.async_mode && read_end && !sync_set && !cmd_wr)
      |=> !sync_break_line;
  endproperty
  a_sync_clr: assert property (p_sync_clr)
    else $error("status read did not clear sync");

  property p_and_line;
    clk_en |=> st_ff.and_line == $past(pin_s.ext_sync_in && pin_s.receive_clock);
  endproperty
  a_and_line: assert property (p_and_line)
    else $error("sync line not registered and");

  property p_dsr;
    (clk_en && !rd_ctrl) |=> io_rdata[USFL_ST_DSR] == !$past(pin_s.dsr_n);
  endproperty
  a_dsr: assert property (p_dsr)
    else $error("dsr bit not inverted input");

  property p_break;
    (clk_en && brk_set && !cmd_wr) |=> sync_break_line;
  endproperty
  a_break: assert property (p_break)
    else $error("break not flagged");

  c_overrun: cover property (clk_en && core_ev.rx_done && st_ff.rx_avail);
  c_break:   cover property (clk_en && brk_set);
  c_sync:    cover property (clk_en && sync_set && in_hunt);
  c_rdclr:   cover property (clk_en && read_end && st_ff.sync_or_break_seen);

endmodule : usfl_status

// ==== testbench/usfl_peer.sv ====
// Far-side model: remote serial peer and modem lines.
// Assumes the bench sets line levels; receive clock runs only when asked.
module usfl_peer
  import usfl_pkg::*;
(
  input  wire logic run_clk,
  input  wire logic cts_n_lv,
  input  wire logic dsr_n_lv,
  input  wire logic rxd_lv,
  input  wire logic sync_lv,
  output usfl_pins_t pins
);
  timeunit 1ns;
  timeprecision 100ps;

  logic rclk = 1'b0;

  // 800 ns receive clock; parked low between frames
  always begin
    #400;
    rclk = run_clk ? ~rclk : 1'b0;
  end

  always_comb begin
    pins = {cts_n_lv, dsr_n_lv, rxd_lv, sync_lv, rclk};
  end
endmodule : usfl_peer

// ==== testbench/usart_status_flags_tb.sv ====
// Self-checking bench for the status and flag block.
// Assumes usfl_pkg and usfl_status are compiled first.
module usart_status_flags_tb;
  import usfl_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  localparam usfl_core_ev_t ev_done = 7'h10;
  localparam usfl_core_ev_t ev_par  = 7'h08;
  localparam usfl_core_ev_t ev_stop = 7'h04;
  localparam usfl_core_ev_t ev_zero = 7'h02;

  logic          sys_clk;
  logic          arst_n;
  logic          clk_en;
  usfl_io_req_t  io_req;
  logic [7:0]    io_rdata;
  usfl_core_ev_t lv;
  usfl_core_ev_t core_ev;
  usfl_pins_t    pins;
  logic          tx_ready_line;
  logic          rx_char_available;
  logic          tx_idle;
  logic          sync_break_line;
  logic          hunt_active;
  logic          sync_mode;
  logic          run_clk;
  logic          cts_n_lv;
  logic          dsr_n_lv;
  logic          rxd_lv;
  logic          sync_lv;
  int            error_cnt;
  int            samples_checked;

  usfl_status uut (
    .sys_clk           (sys_clk),
    .arst_n            (arst_n),
    .clk_en            (clk_en),
    .io_req            (io_req),
    .io_rdata          (io_rdata),
    .core_ev           (core_ev),
    .pins              (pins),
    .tx_ready_line     (tx_ready_line),
    .rx_char_available (rx_char_available),
    .tx_idle           (tx_idle),
    .sync_break_line   (sync_break_line),
    .hunt_active       (hunt_active),
    .sync_mode         (sync_mode)
  );

  usfl_peer peer (
    .run_clk  (run_clk),
    .cts_n_lv (cts_n_lv),
    .dsr_n_lv (dsr_n_lv),
    .rxd_lv   (rxd_lv),
    .sync_lv  (sync_lv),
    .pins     (pins)
  );

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic report_and_stop();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp,
                     input string msg);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t %s seen %h exp %h", $time, msg, seen, exp);
    end
  endtask : chk

  // Inputs always move 10 ns after the rising edge
  task automatic cyc(input int n);
    repeat (n) begin
      @(posedge sys_clk);
      #10;
    end
  endtask : cyc

  task automatic wr(input logic [7:0] data);
    cyc(1);
    io_req = '{addr: USFL_CTRL_ADDR, rd: 1'b0, wr: 1'b1, wdata: data};
    cyc(1);
    io_req.wr = 1'b0;
  endtask : wr

  task automatic rd_on(input logic [7:0] exp);
    cyc(1);
    io_req = '{addr: USFL_CTRL_ADDR, rd: 1'b1, wr: 1'b0, wdata: 8'h00};
    // Snapshot is a flop output, already settled since the edge
    chk(io_rdata, exp, "status");
  endtask : rd_on

  task automatic rd_st(input logic [7:0] exp);
    rd_on(exp);
    cyc(1);
    io_req.rd = 1'b0;
  endtask : rd_st

  task automatic ev(input usfl_core_ev_t e);
    cyc(1);
    core_ev = lv | e;
    cyc(1);
    core_ev = lv;
  endtask : ev

  task automatic wait_sync();
    int k;
    for (k = 0; k < 60 && sync_break_line !== 1'b1; k++) begin
      cyc(1);
    end
    if (k == 60) begin
      error_cnt++;
      report_and_stop();
    end
  endtask : wait_sync

  initial begin
    #3_000_000;
    error_cnt++;
    report_and_stop();
  end

  initial begin
    arst_n = 1'b0;
    clk_en = 1'b1;
    io_req = '0;
    lv = 7'h60;
    core_ev = 7'h60;
    run_clk = 1'b0;
    cts_n_lv = 1'b1;
    dsr_n_lv = 1'b0;
    rxd_lv = 1'b1;
    sync_lv = 1'b0;
    error_cnt = 0;
    samples_checked = 0;
    repeat (5) @(posedge sys_clk);
    chk(io_rdata, 8'h00, "reset");
    @(posedge sys_clk);
    #10;
    arst_n = 1'b1;
    // Async mode, then transmit, receive, error clear
    wr(8'h4e);
    wr(8'h15);
    cyc(4);
    chk(tx_ready_line, 1'b0, "ready cts high");
    rd_st(8'h85);
    cts_n_lv = 1'b0;
    cyc(4);
    chk(tx_ready_line, 1'b1, "ready");
    chk(tx_idle, 1'b1, "idle");
    // Transmitter busy: buffer full and not idle
    lv = 7'h00;
    core_ev = lv;
    cyc(2);
    chk(tx_ready_line, 1'b0, "ready buf full");
    chk(tx_idle, 1'b0, "busy");
    rd_st(8'h80);
    lv = 7'h60;
    core_ev = lv;
    ev(ev_done);
    cyc(2);
    chk(rx_char_available, 1'b1, "rx avail");
    ev(ev_done);
    ev(ev_par);
    ev(ev_stop);
    cyc(2);
    rd_on(8'hbf);
    dsr_n_lv = 1'b1;
    cyc(5);
    chk(io_rdata, 8'hbf, "frozen");
    cyc(1);
    io_req.rd = 1'b0;
    cyc(2);
    rd_st(8'h3f);
    dsr_n_lv = 1'b0;
    wr(8'h15);
    cyc(4);
    rd_st(8'h87);
    // Frozen clock: an event must not land
    clk_en = 1'b0;
    ev(ev_par);
    clk_en = 1'b1;
    cyc(2);
    rd_st(8'h87);
    // Overrun again, then receive disable must clear it
    ev(ev_done);
    cyc(2);
    rd_st(8'h97);
    // Receive disable drops ready; parity still counts
    wr(8'h01);
    cyc(2);
    chk(rx_char_available, 1'b0, "rx off");
    ev(ev_par);
    ev(ev_done);
    cyc(2);
    rd_st(8'h8d);
    wr(8'h15);
    // Break: third zero character with line low
    rxd_lv = 1'b0;
    cyc(4);
    ev(ev_zero);
    ev(ev_zero);
    cyc(2);
    chk(sync_break_line, 1'b0, "early break");
    ev(ev_zero);
    cyc(2);
    rd_st(8'hc5);
    rxd_lv = 1'b1;
    cyc(5);
    chk(sync_break_line, 1'b0, "break end");
    // Software reset, sync mode with external sync
    repeat (3) wr(8'h00);
    wr(8'h40);
    wr(8'h40);
    wr(8'h16);
    wr(8'h16);
    wr(8'h94);
    cyc(2);
    chk(hunt_active, 1'b1, "hunt");
    chk(sync_mode, 1'b1, "sync mode");
    ev(ev_par);
    cyc(2);
    rd_st(8'h85);
    sync_lv = 1'b1;
    run_clk = 1'b1;
    wait_sync();
    chk(hunt_active, 1'b0, "hunt end");
    // Read clear is undone while the sync input stays high
    rd_st(8'hc5);
    // Let the clearing edge pass before looking again
    cyc(1);
    wait_sync();
    sync_lv = 1'b0;
    cyc(4);
    run_clk = 1'b0;
    cyc(10);
    rd_st(8'hc5);
    cyc(2);
    chk(sync_break_line, 1'b0, "read clear");
    report_and_stop();
  end
endmodule : usart_status_flags_tb
